// ==== ecg_map.vh ====
// register map and constants for the embedded controller gpio register bank
`ifndef ECG_MAP_VH
`define ECG_MAP_VH
`define ECG_ADDR_DIR_A   16'h7f18
`define ECG_ADDR_OUT_A   16'h7f19
`define ECG_ADDR_IN_A    16'h7f1a
`define ECG_ADDR_DIR_B   16'h7f1b
`define ECG_ADDR_OUT_B   16'h7f1c
`define ECG_ADDR_IN_B    16'h7f1d
`define ECG_ADDR_DIR_C   16'h7f1e
`define ECG_ADDR_OUT_C   16'h7f1f
`define ECG_ADDR_IN_C    16'h7f20
`define ECG_ADDR_OUTO_LO 16'h7f22
`define ECG_ADDR_OUTO_HI 16'h7f23
`define ECG_ADDR_INO     16'h7f24
`define ECG_RST_VAL      8'h00
`define ECG_MASK_C       8'h3f
`define ECG_MASK_HI      8'h0f
`define ECG_SYNC_STAGES  2
`define ECG_BIDIR_N      22
`define ECG_OUTO_N       12
`define ECG_INO_N        8
// bidirectional pins that float as alternate outputs with main supply down: 6,10,17,20,21
`define ECG_BIDIR_FLOAT  22'h32_0440
// output-only pins that float likewise: 1,5,6,7,8,9
`define ECG_OUTO_FLOAT   12'h3e2
`endif

// ==== ecg_sync.v ====
// two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module ecg_sync #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire         nrst,
  input  wire         ce,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end
    else if (ce)
    begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule

// ==== ecg_gpio_regs.v ====
// gpio register bank on the embedded controller external data bus
`timescale 1ns/1ps
`include "ecg_map.vh"
module ecg_gpio_regs #(
  parameter BN = `ECG_BIDIR_N,
  parameter ON = `ECG_OUTO_N,
  parameter IN = `ECG_INO_N
) (
  input  wire          clock,
  input  wire          nrst,
  input  wire          ce,
  input  wire [15:0]   xaddr,
  input  wire          xwr,
  input  wire          xrd,
  input  wire [7:0]    xwdata,
  output reg  [7:0]    xrdata,
  input  wire          main_supply_good,
  input  wire [BN-1:0] bidir_alt_sel,
  input  wire [BN-1:0] bidir_alt_out,
  input  wire [ON-1:0] outo_alt_sel,
  input  wire [ON-1:0] outo_alt_out,
  input  wire [BN-1:0] bidir_in,
  output reg  [BN-1:0] bidir_out,
  output reg  [BN-1:0] bidir_oe,
  output reg  [ON-1:0] dedicated_output_pins,
  output reg  [ON-1:0] dedicated_output_oe,
  input  wire [IN-1:0] dedicated_input_pins,
  output wire [BN-1:0] bidir_in_sync
);
  // the bus reaches only controller data space; no host decode exists
  reg  [7:0]    dir_a_r;
  reg  [7:0]    out_a_r;
  reg  [7:0]    dir_b_r;
  reg  [7:0]    out_b_r;
  reg  [5:0]    dir_c_r;
  reg  [5:0]    out_c_r;
  reg  [7:0]    outo_lo_r;
  reg  [3:0]    outo_hi_r;
  wire [BN-1:0] bin_s;
  wire [IN-1:0] ino_s;
  wire [21:0]   dir_all;
  wire [21:0]   out_all;
  wire [11:0]   outo_all;
  reg  [BN-1:0] boe_nxt;
  reg  [BN-1:0] bout_nxt;
  reg  [ON-1:0] ooe_nxt;
  reg  [ON-1:0] oout_nxt;
  reg  [7:0]    rd_nxt;

  ecg_sync #(.W(BN)) u_sync_b (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .d     (bidir_in),
    .q     (bin_s)
  );

  ecg_sync #(.W(IN)) u_sync_i (
    .clock (clock),
    .nrst  (nrst),
    .ce    (ce),
    .d     (dedicated_input_pins),
    .q     (ino_s)
  );

  assign bidir_in_sync = bin_s;
  assign dir_all  = {dir_c_r, dir_b_r, dir_a_r};
  assign out_all  = {out_c_r, out_b_r, out_a_r};
  assign outo_all = {outo_hi_r, outo_lo_r};

  // register writes; input addresses have no write path
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dir_a_r   <= `ECG_RST_VAL;
      out_a_r   <= `ECG_RST_VAL;
      dir_b_r   <= `ECG_RST_VAL;
      out_b_r   <= `ECG_RST_VAL;
      dir_c_r   <= 6'h00;
      out_c_r   <= 6'h00;
      outo_lo_r <= `ECG_RST_VAL;
      outo_hi_r <= 4'h0;
    end
    else if (ce && xwr)
    begin
      if (xaddr == `ECG_ADDR_DIR_A)
        dir_a_r <= xwdata;
      else if (xaddr == `ECG_ADDR_OUT_A)
        out_a_r <= xwdata;
      else if (xaddr == `ECG_ADDR_DIR_B)
        dir_b_r <= xwdata;
      else if (xaddr == `ECG_ADDR_OUT_B)
        out_b_r <= xwdata;
      else if (xaddr == `ECG_ADDR_DIR_C)
        dir_c_r <= xwdata[5:0];
      else if (xaddr == `ECG_ADDR_OUT_C)
        out_c_r <= xwdata[5:0];
      else if (xaddr == `ECG_ADDR_OUTO_LO)
        outo_lo_r <= xwdata;
      else if (xaddr == `ECG_ADDR_OUTO_HI)
        outo_hi_r <= xwdata[3:0];
    end
  end

  // read mux; unmapped addresses read zero
  always @*
  begin
    rd_nxt = 8'h00;
    if (xaddr == `ECG_ADDR_DIR_A)
      rd_nxt = dir_a_r;
    else if (xaddr == `ECG_ADDR_OUT_A)
      rd_nxt = out_a_r;
    else if (xaddr == `ECG_ADDR_IN_A)
      rd_nxt = bin_s[7:0];
    else if (xaddr == `ECG_ADDR_DIR_B)
      rd_nxt = dir_b_r;
    else if (xaddr == `ECG_ADDR_OUT_B)
      rd_nxt = out_b_r;
    else if (xaddr == `ECG_ADDR_IN_B)
      rd_nxt = bin_s[15:8];
    else if (xaddr == `ECG_ADDR_DIR_C)
      rd_nxt = {2'b00, dir_c_r};
    else if (xaddr == `ECG_ADDR_OUT_C)
      rd_nxt = {2'b00, out_c_r};
    else if (xaddr == `ECG_ADDR_IN_C)
      rd_nxt = {2'b00, bin_s[21:16]} & `ECG_MASK_C;
    else if (xaddr == `ECG_ADDR_OUTO_LO)
      rd_nxt = outo_lo_r;
    else if (xaddr == `ECG_ADDR_OUTO_HI)
      rd_nxt = {4'h0, outo_hi_r} & `ECG_MASK_HI;
    else if (xaddr == `ECG_ADDR_INO)
      rd_nxt = ino_s;
  end

  // pin drive: direction from register, alt selects the data and, with main supply down, floats the listed pins
  always @*
  begin
    boe_nxt  = dir_all;
    bout_nxt = (bidir_alt_sel & bidir_alt_out) | (~bidir_alt_sel & out_all);
    ooe_nxt  = {ON{1'b1}};
    oout_nxt = (outo_alt_sel & outo_alt_out) | (~outo_alt_sel & outo_all);
    if (!main_supply_good)
    begin
      boe_nxt = boe_nxt & ~(bidir_alt_sel & `ECG_BIDIR_FLOAT);
      ooe_nxt = ooe_nxt & ~(outo_alt_sel & `ECG_OUTO_FLOAT);
    end
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      xrdata                <= 8'h00;
      bidir_out             <= {BN{1'b0}};
      bidir_oe              <= {BN{1'b0}};
      dedicated_output_pins <= {ON{1'b0}};
      dedicated_output_oe   <= {ON{1'b1}};
    end
    else if (ce)
    begin
      if (xrd)
        xrdata <= rd_nxt;
      bidir_out             <= bout_nxt;
      bidir_oe              <= boe_nxt;
      dedicated_output_pins <= oout_nxt;
      dedicated_output_oe   <= ooe_nxt;
    end
  end
endmodule

// ==== ecg_bus_host.sv ====
// controller-side bus model issuing one register access at a time
`timescale 1ns/1ps
module ecg_bus_host (
  input  wire        clock,
  output reg  [15:0] xaddr = 0,
  output reg         xwr = 0,
  output reg         xrd = 0,
  output reg  [7:0]  xwdata = 0
);
  // sole accessor of the bank; held over one rising edge, then scrambled
  task acc(input [15:0] a, input w, input [7:0] d);
    begin
      @(negedge clock);
      {xaddr, xwr, xrd, xwdata} = {a, w, !w, d};
      @(negedge clock);
      {xaddr, xwr, xrd, xwdata} = {~a, 2'b00, ~d};
    end
  endtask
endmodule

// ==== ecg_gpio_regs_asserts.sv ====
// port assertions for the controller gpio register bank
`timescale 1ns/1ps
module ecg_gpio_chk (
  input wire        clock,
  input wire        nrst,
  input wire        ce,
  input wire [15:0] xaddr,
  input wire        xwr,
  input wire        xrd,
  input wire [7:0]  xwdata,
  input wire [7:0]  xrdata,
  input wire        main_supply_good,
  input wire [21:0] bidir_alt_sel,
  input wire [11:0] outo_alt_sel,
  input wire [21:0] bidir_oe,
  input wire [11:0] dedicated_output_pins,
  input wire [11:0] dedicated_output_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  dir_a_pins_a: assert property (ce && xwr && xaddr == 16'h7f18 ##1 ce |=>
    bidir_oe[5:0] == $past(xwdata[5:0], 2)) else $error("dir a not on pins");
  dir_b_pins_a: assert property (ce && xwr && xaddr == 16'h7f1b ##1 ce |=>
    bidir_oe[15:11] == $past(xwdata[7:3], 2)) else $error("dir b not on pins");
  out_lo_pins_a: assert property (ce && xwr && xaddr == 16'h7f22 ##1 ce &&
    outo_alt_sel == 0 |=> dedicated_output_pins[7:0] == $past(xwdata, 2)) else $error("low bank");
  out_hi_pins_a: assert property (ce && xwr && xaddr == 16'h7f23 ##1 ce &&
    outo_alt_sel == 0 |=> dedicated_output_pins[11:8] == $past(xwdata[3:0], 2)) else $error("hi");
  dir_c_top_a: assert property (ce && xrd && xaddr == 16'h7f1e |=>
    xrdata[7:6] == 2'b00) else $error("dir c top bits set");
  out_c_top_a: assert property (ce && xrd && xaddr == 16'h7f1f |=>
    xrdata[7:6] == 2'b00) else $error("out c top bits set");
  in_c_top_a: assert property (ce && xrd && xaddr == 16'h7f20 |=>
    xrdata[7:6] == 2'b00) else $error("in c top bits set");
  float_pin_a: assert property (ce && !main_supply_good && bidir_alt_sel[6] |=>
    !bidir_oe[6]) else $error("pin 6 driven while main supply down");
  float_out_a: assert property (ce && !main_supply_good && outo_alt_sel[1] |=>
    !dedicated_output_oe[1]) else $error("output pin 1 driven while main supply down");
  cover property (ce && xwr && xaddr == 16'h7f18);
  cover property (!main_supply_good && bidir_alt_sel[6]);
  cover property (ce && xrd && xaddr == 16'h7f24);
endmodule
bind ecg_gpio_regs ecg_gpio_chk i_ecg_gpio_chk (.*);

// ==== test_ecg_gpio_regs.sv ====
// self-checking bench for the controller gpio register bank
`timescale 1ns/1ps
module test_ecg_gpio_regs;
  reg                clock = 0, nrst = 0, ce = 1, main_supply_good = 1, rd_p = 0;
  reg  [21:0]        bidir_alt_sel = 0, ext = 0;
  reg  [11:0]        outo_alt_sel = 0;
  reg  [7:0]         dedicated_input_pins = 0, ev, v [0:7], exp_q [$];
  integer            seed = 54, i, cyc = 0, error_cnt = 0, n_checks = 0;
  wire [15:0]        xaddr;
  wire [7:0]         xwdata, xrdata;
  wire [21:0]        bidir_out, bidir_oe;
  wire               xwr, xrd;
  wire [21:0]        pin = bidir_oe & bidir_out | ~bidir_oe & ext;
  localparam [15:0]  adr [0:7] = '{16'h7f18, 16'h7f19, 16'h7f1b, 16'h7f1c, 16'h7f1e, 16'h7f1f,
                                   16'h7f22, 16'h7f23};
  localparam [7:0]   msk [0:7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'h0f};
  always #2.5 clock = ~clock;
  ecg_bus_host i_ecg_bus_host (.*);
  ecg_gpio_regs i_ecg_gpio_regs (.*, .bidir_alt_out(~ext), .outo_alt_out(ext[11:0]),
    .bidir_in(pin), .dedicated_output_pins(), .dedicated_output_oe(), .bidir_in_sync());
  task rd(input [15:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      i_ecg_bus_host.acc(a, 1'b0, 8'h00);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (rd_p)
    begin
      ev = exp_q.pop_front();
      n_checks = n_checks + 1;
      if (xrdata !== ev)
        $display("Error %0t read %h expected %h", $time, xrdata, ev);
      error_cnt = error_cnt + (xrdata !== ev);
    end
    rd_p <= ce && xrd;
    error_cnt = error_cnt + (cyc == 3000);
    if (cyc == 3000)
      $display("Error %0t timeout", $time);
    if (cyc == 3000)
      end_of_test;
  end
  initial
  begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    nrst = 1;
    for (i = 0; i < 8; i = i + 1)
      rd(adr[i], 8'h00);
    $display("reset values done");
    repeat (2)
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        v[i] = 8'($random(seed));
        i_ecg_bus_host.acc(adr[i], 1'b1, v[i]);
        i_ecg_bus_host.acc(16'h7f1a + 16'(3 * (i % 3)), 1'b1, ~v[i]);
        rd(adr[i], v[i] & msk[i]);
      end
      ext = 22'($random(seed));
      dedicated_input_pins = 8'($random(seed));
      repeat (3) @(negedge clock);
      rd(16'h7f1a, v[0] & v[1] | ~v[0] & ext[7:0]);
      rd(16'h7f1d, v[2] & v[3] | ~v[2] & ext[15:8]);
      rd(16'h7f20, (v[4] & v[5] | ~v[4] & {2'b00, ext[21:16]}) & 8'h3f);
      rd(16'h7f24, dedicated_input_pins);
      rd(16'h7f21, 8'h00);
      $display("random round done");
    end
    ce = 0;
    i_ecg_bus_host.acc(16'h7f19, 1'b1, ~v[1]);
    ce = 1;
    rd(16'h7f19, v[1]);
    $display("clock enable done");
    main_supply_good = 0;
    bidir_alt_sel = {22{1'b1}};
    outo_alt_sel = {12{1'b1}};
    repeat (4) @(negedge clock);
    rd(16'h7f1a, v[0] & 8'hbf & ~ext[7:0] | ~(v[0] & 8'hbf) & ext[7:0]);
    repeat (2) @(negedge clock);
    $display("alternate function done");
    end_of_test;
  end
endmodule
